/* hw/spi_baud_pkg.sv */
package spi_baud_pkg;
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          FIELD_W    = 3;
  localparam int          CNT_W      = 11;
  localparam int          IRQ_W      = 3;
  // Printed offsets are not word aligned: they are indices
  localparam logic [7:0]  DIV_INDEX  = 8'hea;
  localparam logic [7:0]  FLAG_INDEX = 8'heb;
  localparam logic [7:0]  STAT_INDEX = 8'hf0;
  localparam logic [7:0]  MASK_INDEX = 8'hf1;
  localparam logic [ADDR_W-1:0] DIV_ADDR  = {2'h0, DIV_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] FLAG_ADDR = {2'h0, FLAG_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MASK_ADDR = {2'h0, MASK_INDEX, 2'h0};
  localparam int          PRESCALE_LSB = 4;
  localparam int          RATE_LSB     = 0;
  localparam logic [7:0]  DIV_WMASK    = 8'h77;
  localparam logic [7:0]  DIV_RESET    = 8'h00;
  localparam int          RX_BIT       = 7;
  localparam int          TX_BIT       = 5;
  localparam int          MODE_FAULT_FLAG_BIT     = 4;
  localparam logic [7:0]  FLAG_USED    = 8'hb0;
  localparam int          IRQ_RX       = 0;
  localparam int          IRQ_MODE_FAULT_FLAG     = 1;
  localparam int          IRQ_TX       = 2;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
  localparam logic        SCK_IDLE     = 1'b0;

  typedef struct packed {
    logic [7:0]        divider;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              rx_flag;
    logic              tx_flag;
    logic              mode_fault_flag_flag;
    logic              rx_armed;
    logic              tx_armed;
    logic              mode_fault_flag_armed;
    logic              ss_prev_n;
    logic [CNT_W-1:0]  cnt;
    logic              sck;
    logic              tx_load;
    logic              abort_idle;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic              irq;
  } state_s;

  // Half of (p+1)*2^(r+1)
  function automatic logic [CNT_W-1:0] half_count(
    input logic [FIELD_W-1:0] p,
    input logic [FIELD_W-1:0] r);
    logic [CNT_W-1:0] base;
    base = CNT_W'(p) + CNT_W'(1);
    return base << r;
  endfunction
endpackage

/* hw/spi_baud_flags.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_baud_flags (
  input  wire logic                               clk,
  input  wire logic                               reset,
  input  wire logic                               ce,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [spi_baud_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [spi_baud_pkg::DATA_W-1:0]    pwdata,
  output logic      [spi_baud_pkg::DATA_W-1:0]    prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               master_mode,
  input  wire logic                               mode_fault_detect_enable,
  input  wire logic                               serial_irq_enable,
  input  wire logic                               tx_irq_enable,
  input  wire logic                               ss_in_n,
  input  wire logic                               sck_run,
  input  wire logic                               rx_byte_done,
  input  wire logic                               tx_taken,
  input  wire logic                               data_read,
  input  wire logic                               data_write,
  input  wire logic                               ctrl_one_write,
  output logic                                    sck,
  output logic                                    tx_load,
  output logic                                    abort_idle,
  output logic                                    irq
);
  spi_baud_pkg::state_s s;
  spi_baud_pkg::state_s next_s;

  logic                                  rd_setup;
  logic                                  done;
  logic                                  wr_div;
  logic                                  rd_flags;
  logic                                  rd_stat;
  logic                                  wr_mask;
  logic                                  fault;
  logic [7:0]                            new_div;
  logic [spi_baud_pkg::CNT_W-1:0]        half;
  logic [spi_baud_pkg::IRQ_W-1:0]        events;
  logic [spi_baud_pkg::DATA_W-1:0]       rdata;
  logic                                  hit;

  // One-wait-state decode; answer registered so pready comes from a flop
  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    unique case (paddr)
      spi_baud_pkg::DIV_ADDR:  rdata[7:0] = s.divider;
      spi_baud_pkg::FLAG_ADDR: begin
        rdata[spi_baud_pkg::RX_BIT]   = s.rx_flag;
        rdata[spi_baud_pkg::TX_BIT]   = s.tx_flag;
        rdata[spi_baud_pkg::MODE_FAULT_FLAG_BIT] = s.mode_fault_flag_flag;
      end
      spi_baud_pkg::STAT_ADDR:
        rdata[spi_baud_pkg::IRQ_W-1:0] = s.irq_stat;
      spi_baud_pkg::MASK_ADDR:
        rdata[spi_baud_pkg::IRQ_W-1:0] = s.irq_mask;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_setup = psel && penable && !s.pready;
    done     = psel && penable && s.pready;
    wr_div   = done && pwrite && paddr == spi_baud_pkg::DIV_ADDR;
    wr_mask  = done && pwrite && paddr == spi_baud_pkg::MASK_ADDR;
    rd_flags = done && !pwrite && paddr == spi_baud_pkg::FLAG_ADDR;
    rd_stat  = done && !pwrite && paddr == spi_baud_pkg::STAT_ADDR;
    // Reserved divider bits keep their value on write
    new_div  = (s.divider & ~spi_baud_pkg::DIV_WMASK)
             | (pwdata[7:0] & spi_baud_pkg::DIV_WMASK);
    half     = spi_baud_pkg::half_count(
                 s.divider[spi_baud_pkg::PRESCALE_LSB +:
                           spi_baud_pkg::FIELD_W],
                 s.divider[spi_baud_pkg::RATE_LSB +:
                           spi_baud_pkg::FIELD_W]);
    fault    = master_mode && mode_fault_detect_enable
             && s.ss_prev_n && !ss_in_n;
  end

  always_comb begin
    next_s            = s;
    events            = '0;
    next_s.pready     = rd_setup;
    next_s.pslverr    = rd_setup && !hit;
    next_s.prdata     = (rd_setup && !pwrite) ? rdata : '0;
    next_s.ss_prev_n  = ss_in_n;
    next_s.tx_load    = 1'b0;
    next_s.abort_idle = fault;

    if (wr_div) begin
      next_s.divider = new_div;
      // Any field change in master mode kills the frame
      if (master_mode && new_div != s.divider)
        next_s.abort_idle = 1'b1;
    end

    // Arming looks at the value the read returned
    if (rd_flags && s.prdata[spi_baud_pkg::RX_BIT])
      next_s.rx_armed = 1'b1;
    if (rd_flags && s.prdata[spi_baud_pkg::TX_BIT])
      next_s.tx_armed = 1'b1;
    if (rd_flags && s.prdata[spi_baud_pkg::MODE_FAULT_FLAG_BIT])
      next_s.mode_fault_flag_armed = 1'b1;

    if (data_read && s.rx_armed) begin
      next_s.rx_flag  = 1'b0;
      next_s.rx_armed = 1'b0;
    end
    if (data_write) begin
      next_s.tx_armed = 1'b0;
      if (s.tx_armed) begin
        next_s.tx_load = 1'b1;
        next_s.tx_flag = 1'b0;
      end
    end
    if (ctrl_one_write && s.mode_fault_flag_armed) begin
      next_s.mode_fault_flag_flag  = 1'b0;
      next_s.mode_fault_flag_armed = 1'b0;
    end
    // Sets land after clears so a same-cycle event wins
    if (rx_byte_done)
      next_s.rx_flag = 1'b1;
    if (tx_taken)
      next_s.tx_flag = 1'b1;
    if (fault)
      next_s.mode_fault_flag_flag = 1'b1;

    events[spi_baud_pkg::IRQ_RX]   = rx_byte_done;
    events[spi_baud_pkg::IRQ_MODE_FAULT_FLAG] = fault && serial_irq_enable;
    events[spi_baud_pkg::IRQ_TX]   = next_s.tx_flag && !s.tx_flag;
    if (rd_stat)
      next_s.irq_stat = '0;
    next_s.irq_stat = next_s.irq_stat | events;
    if (wr_mask)
      next_s.irq_mask = pwdata[spi_baud_pkg::IRQ_W-1:0];
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask)
               || (tx_irq_enable && next_s.tx_flag);

    // Counter restarts on abort so the next frame gets a full half
    if (!master_mode || !sck_run || next_s.abort_idle) begin
      next_s.cnt = '0;
      next_s.sck = spi_baud_pkg::SCK_IDLE;
    end else if (s.cnt == half - 1'b1) begin
      next_s.cnt = '0;
      next_s.sck = !s.sck;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s            <= '0;
      s.divider    <= spi_baud_pkg::DIV_RESET;
      s.tx_flag    <= 1'b1;
      s.ss_prev_n  <= 1'b1;
      s.sck        <= spi_baud_pkg::SCK_IDLE;
      s.irq_mask   <= spi_baud_pkg::MASK_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  always_comb begin
    prdata     = s.prdata;
    pready     = s.pready;
    pslverr    = s.pslverr;
    sck        = s.sck;
    tx_load    = s.tx_load;
    abort_idle = s.abort_idle;
    irq        = s.irq;
  end

  a_sck_half_toggle: assert property (
    @(posedge clk) disable iff (reset)
    ce && master_mode && sck_run && !next_s.abort_idle
    && s.cnt == half - 1'b1 |=> sck != $past(sck))
    else $error("serial clock missed its half-period toggle");

  a_sck_hold: assert property (
    @(posedge clk) disable iff (reset)
    ce && master_mode && sck_run && !next_s.abort_idle
    && s.cnt != half - 1'b1 |=> sck == $past(sck))
    else $error("serial clock toggled before half period");

  a_cnt_bound: assert property (
    @(posedge clk) disable iff (reset)
    s.cnt < half)
    else $error("divider counter ran past half period");

  a_sck_idle: assert property (
    @(posedge clk) disable iff (reset)
    ce && !master_mode |=> sck == spi_baud_pkg::SCK_IDLE && s.cnt == '0)
    else $error("serial clock running outside master mode");

  a_div_abort: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_div && master_mode && new_div != s.divider
    |=> abort_idle && sck == spi_baud_pkg::SCK_IDLE && s.cnt == '0)
    else $error("divider change did not abort");

  a_div_reserved: assert property (
    @(posedge clk) disable iff (reset)
    ce |=> (s.divider & ~spi_baud_pkg::DIV_WMASK) == 8'h00)
    else $error("reserved divider bits changed");

  a_div_write: assert property (
    @(posedge clk) disable iff (reset)
    ce && wr_div |=> s.divider == $past(new_div))
    else $error("divider write lost");

  a_rx_set: assert property (
    @(posedge clk) disable iff (reset)
    ce && rx_byte_done |=> s.rx_flag)
    else $error("receive flag not set");

  a_rx_event: assert property (
    @(posedge clk) disable iff (reset)
    ce && rx_byte_done |=> s.irq_stat[spi_baud_pkg::IRQ_RX])
    else $error("receive event not recorded");

  a_rx_clear_only: assert property (
    @(posedge clk) disable iff (reset)
    ce && s.rx_flag && !(data_read && s.rx_armed) |=> s.rx_flag)
    else $error("receive flag cleared without sequence");

  a_rx_clear: assert property (
    @(posedge clk) disable iff (reset)
    ce && data_read && s.rx_armed && !rx_byte_done |=> !s.rx_flag)
    else $error("receive flag not cleared by sequence");

  a_tx_set: assert property (
    @(posedge clk) disable iff (reset)
    ce && tx_taken |=> s.tx_flag)
    else $error("transmit empty flag not set");

  a_tx_ignore: assert property (
    @(posedge clk) disable iff (reset)
    ce && data_write && !s.tx_armed
    |=> !tx_load && (s.tx_flag == $past(s.tx_flag) || $past(tx_taken)))
    else $error("unarmed data write was taken");

  a_tx_load: assert property (
    @(posedge clk) disable iff (reset)
    ce && data_write && s.tx_armed && !tx_taken |=> tx_load && !s.tx_flag)
    else $error("armed data write not loaded");

  a_mode_fault_flag_set: assert property (
    @(posedge clk) disable iff (reset)
    ce && fault |=> s.mode_fault_flag_flag && abort_idle)
    else $error("mode fault not flagged");

  a_mode_fault_flag_clear: assert property (
    @(posedge clk) disable iff (reset)
    ce && s.mode_fault_flag_flag && !(ctrl_one_write && s.mode_fault_flag_armed) |=> s.mode_fault_flag_flag)
    else $error("mode fault cleared without sequence");

  a_mode_fault_flag_release: assert property (
    @(posedge clk) disable iff (reset)
    ce && ctrl_one_write && s.mode_fault_flag_armed && !fault |=> !s.mode_fault_flag_flag)
    else $error("mode fault not cleared by sequence");

  a_flags_zeros: assert property (
    @(posedge clk) disable iff (reset)
    ce && rd_setup && !pwrite && paddr == spi_baud_pkg::FLAG_ADDR
    |=> (prdata[7:0] & ~spi_baud_pkg::FLAG_USED) == 8'h00 && pready)
    else $error("status unused bits not zero");

  a_mode_fault_flag_irq: assert property (
    @(posedge clk) disable iff (reset)
    ce && fault && serial_irq_enable |=> s.irq_stat[spi_baud_pkg::IRQ_MODE_FAULT_FLAG])
    else $error("mode fault event not recorded");

  a_irq_level: assert property (
    @(posedge clk) disable iff (reset)
    ce && s.irq_stat[spi_baud_pkg::IRQ_MODE_FAULT_FLAG] && !rd_stat && !wr_mask
    && s.irq_mask[spi_baud_pkg::IRQ_MODE_FAULT_FLAG] |=> irq)
    else $error("mode fault interrupt missing");

  a_tx_irq: assert property (
    @(posedge clk) disable iff (reset)
    ce && tx_irq_enable && s.tx_flag
    && !(data_write && s.tx_armed) |=> irq)
    else $error("transmit interrupt missing");

  c_tx_load: cover property (@(posedge clk) disable iff (reset) tx_load);
  c_abort:   cover property (@(posedge clk) disable iff (reset) abort_idle);
  c_rx_clr:  cover property (@(posedge clk) disable iff (reset)
    s.rx_flag ##1 !s.rx_flag);
  c_irq:     cover property (@(posedge clk) disable iff (reset) irq);
  c_mode_fault_flag:    cover property (@(posedge clk) disable iff (reset) s.mode_fault_flag_flag);
endmodule
`default_nettype wire

/* verification/spi_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_far_end (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        fault,
  input  wire logic        sck,
  output logic             ss_in_n,
  output logic [15:0]      period,
  output logic [15:0]      rises
);
  logic        sck_d;
  logic [15:0] since;
  // A rival master pulls select low; idle level is high
  assign ss_in_n = ~fault;
  // Idle level of the serial clock is low, so no false edge after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_d  <= 1'b0;
      since  <= 16'h0;
      rises  <= 16'h0;
      period <= 16'h0;
    end else begin
      sck_d <= sck;
      since <= (sck && !sck_d) ? 16'h1 : since + 16'h1;
      if (sck && !sck_d) begin
        rises  <= rises + 16'h1;
        period <= since;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/tb_spi_baud_and_status_flags.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_spi_baud_and_status_flags;
  logic        clk, reset, psel, penable, pwrite, err, fault, ce;
  logic        master_mode, mode_fault_flag_en, sirq_en, txirq_en, sck_run;
  logic        pready, pslverr, sck, tx_load, abort_idle, irq, ss_in_n;
  logic [4:0]  ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] period, rises;
  logic [7:0]  v;
  int          err_count, samples_checked, aborts, loads, seed, a0;

  spi_baud_flags dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_mode(master_mode), .mode_fault_detect_enable(mode_fault_flag_en),
    .serial_irq_enable(sirq_en), .tx_irq_enable(txirq_en),
    .ss_in_n(ss_in_n), .sck_run(sck_run), .rx_byte_done(ev[0]),
    .tx_taken(ev[1]), .data_read(ev[2]), .data_write(ev[3]),
    .ctrl_one_write(ev[4]), .sck(sck), .tx_load(tx_load),
    .abort_idle(abort_idle), .irq(irq));
  spi_far_end far (.clk(clk), .reset(reset), .fault(fault), .sck(sck),
    .ss_in_n(ss_in_n),
    .period(period), .rises(rises));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (abort_idle === 1'b1) aborts++;
    if (tx_load === 1'b1) loads++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic flags(input logic [7:0] exp);
    apb(1'b0, spi_baud_pkg::FLAG_ADDR, 32'h0);
    check(rd, {24'h0, exp});
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, fault} = '0;
    {master_mode, mode_fault_flag_en, sirq_en, txirq_en, sck_run} = '0;
    ce = 1'b1;
    reset = 1'b1;
    seed = 32'ha316;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    flags(8'h20);
    apb(1'b1, spi_baud_pkg::FLAG_ADDR, 32'hff);
    flags(8'h20);
    apb(1'b1, spi_baud_pkg::DIV_ADDR, 32'hff);
    apb(1'b0, spi_baud_pkg::DIV_ADDR, 32'h0);
    check(rd, 32'h77);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, err}, 32'h1);
    master_mode <= 1'b1;
    mode_fault_flag_en <= 1'b1;
    a0 = aborts;
    // Same value is no change, so no abort
    apb(1'b1, spi_baud_pkg::DIV_ADDR, 32'h77);
    apb(1'b1, spi_baud_pkg::DIV_ADDR, 32'h12);
    repeat (2) @(posedge clk);
    check(32'(aborts - a0), 32'h1);
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h77 : 8'($random(seed)) & 8'h77;
      sck_run <= 1'b0;
      apb(1'b1, spi_baud_pkg::DIV_ADDR, {24'h0, v});
      sck_run <= 1'b1;
      a0 = rises;
      // First rise period is stale; the second spans one divisor
      while (rises < a0 + 2) begin
        @(posedge clk);
      end
      check(32'(period), (32'(v[6:4]) + 1) << (32'(v[2:0]) + 1));
    end
    sck_run <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, sck}, 32'h0);
    pulse(0);
    pulse(2);
    flags(8'ha0);
    pulse(2);
    flags(8'h20);
    // Frozen clock enable must swallow the receive event
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    flags(8'h20);
    // Earlier status reads saw the empty flag, so this write is armed
    a0 = loads;
    pulse(3);
    repeat (2) @(posedge clk);
    check(32'(loads - a0), 32'h1);
    flags(8'h00);
    pulse(3);
    repeat (2) @(posedge clk);
    check(32'(loads - a0), 32'h1);
    flags(8'h00);
    pulse(1);
    flags(8'h20);
    apb(1'b0, spi_baud_pkg::STAT_ADDR, 32'h0);
    sirq_en <= 1'b1;
    apb(1'b1, spi_baud_pkg::MASK_ADDR, 32'h2);
    a0 = aborts;
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(aborts - a0), 32'h1);
    check({31'h0, irq}, 32'h1);
    fault <= 1'b0;
    pulse(4);
    flags(8'h30);
    pulse(4);
    flags(8'h20);
    apb(1'b0, spi_baud_pkg::STAT_ADDR, 32'h0);
    check(rd, 32'h2);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    txirq_en <= 1'b1;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    txirq_en <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
